//--- design/pmc_pkg.sv
package pmc_pkg;
  // ********************************************
  // Register map
  // ********************************************
  localparam logic [15:0] PMC_CTRL1_IDX   = 16'hfff0;       // Index of power_mode_control_1
  localparam logic [15:0] PMC_CTRL2_IDX   = 16'hfff1;       // Index of power_mode_control_2
  localparam logic [31:0] PMC_CTRL1_ADDR  = {14'h0000, PMC_CTRL1_IDX, 2'b00};
  localparam logic [31:0] PMC_CTRL2_ADDR  = {14'h0000, PMC_CTRL2_IDX, 2'b00};
  localparam logic [7:0]  PMC_CTRL1_RST   = 8'h07;          // Value after reset
  localparam logic [7:0]  PMC_CTRL2_RST   = 8'he0;
  localparam logic [7:0]  PMC_CTRL1_FIXED = 8'h04;          // Bits that always read as one
  localparam logic [7:0]  PMC_CTRL2_FIXED = 8'he0;

  // ********************************************
  // Field positions
  // ********************************************
  localparam int PMC_DEEP_STOP_BIT = 7;                     // power_mode_control_1
  localparam int PMC_WAIT_SEL_LSB  = 4;
  localparam int PMC_LOW_CLK_BIT   = 3;
  localparam int PMC_MED_DIV_LSB   = 0;
  localparam int PMC_NOISE_BIT     = 4;                     // power_mode_control_2
  localparam int PMC_DIRECT_BIT    = 3;
  localparam int PMC_MED_SPEED_BIT = 2;
  localparam int PMC_SUB_DIV_LSB   = 0;

  // ********************************************
  // Timing and ratios
  // ********************************************
  localparam int          PMC_WAIT_STATES_MIN = 8192;       // Shortest settling wait, in states
  localparam int          PMC_CNT_W           = 18;         // Holds the longest wait
  localparam logic [7:0]  PMC_MED_DIV_MIN     = 8'd16;      // Oscillator divide for code 00
  localparam logic [3:0]  PMC_SUB_DIV_MAX     = 4'd8;       // Watch clock divide for code 00
  localparam logic [4:0]  PMC_NOISE_DIV_SLOW  = 5'd16;
  localparam logic [4:0]  PMC_NOISE_DIV_FAST  = 5'd4;

  // ********************************************
  // Operating modes, Gray coded along the usual path
  // ********************************************
  typedef enum logic [3:0] {
    PMC_ACT_HS   = 4'h0,
    PMC_SLEEP_HS = 4'h1,
    PMC_SLEEP_MS = 4'h3,
    PMC_ACT_MS   = 4'h2,
    PMC_STANDBY  = 4'h6,
    PMC_SETTLE   = 4'h7,
    PMC_WATCH    = 4'h5,
    PMC_SUBACT   = 4'h4,
    PMC_SUBSLEEP = 4'hc
  } pmc_mode_t;
endpackage : pmc_pkg

//--- design/pmc_power_mode_ctrl.sv
`timescale 1ns/1ns
// How it works
// [RULE1] Control one resets 0x07, bit2 fixed one
// [RULE2] Deep stop clear: halt gives sleep/subsleep
// [RULE3] Deep stop set: halt gives standby/watch
// [RULE4] Wait code picks settling states on wake
// [RULE5] Software picks wait of ten ms or more
// [RULE6] Low clock picks system or subclock after watch
// [RULE7] Medium divider gives osc over 16..128
// [RULE8] Software changes medium divider only when safe
// [RULE9] Control two resets 0xE0, top bits fixed
// [RULE10] Noise bit picks osc over 16 or 4
// [RULE11] Software keeps noise bit clear 2-10 MHz
// [RULE12] Direct switch clear: halt enters low power
// [RULE13] Direct switch from high speed
// [RULE14] Direct switch from medium speed
// [RULE15] Direct switch from subactive to active
// [RULE16] Medium speed bit picks speed after wake
// [RULE17] Subclock divider gives watch clock over 8,4,2
// [RULE18] Subclock divider frozen during subactive
// [RULE19] Standby holds ports in high impedance
// [RULE20] Standby and watch ignore external interrupts
// [RULE21] Watch timer runs in sub modes if selected
// [RULE22] Deep stop halt: standby or watch by timekeeper
// [RULE23] Clock held until settling count ends
// [RULE24] Halt samples registers, drives encoded mode
module pmc_power_mode_ctrl
  import pmc_pkg::*;
#(
  parameter int WAIT_BASE_STATES = PMC_WAIT_STATES_MIN      // Shortest settling wait in cycles
) (
  input  wire logic        clk_sys_in,                      // System clock, 10 MHz
  input  wire logic        nrst_in,                         // Asynchronous reset, active low
  input  wire logic        hsel_in,                         // AHB slave select
  input  wire logic [31:0] haddr_in,                        // AHB byte address
  input  wire logic [1:0]  htrans_in,                       // AHB transfer type
  input  wire logic        hwrite_in,                       // AHB write strobe
  input  wire logic [2:0]  hsize_in,                        // AHB size, word only
  input  wire logic        hready_in,                       // AHB bus ready
  input  wire logic [31:0] hwdata_in,                       // AHB write data
  output logic      [31:0] hrdata_out,                      // AHB read data
  output logic             hreadyout_out,                   // AHB slave ready
  output logic             hresp_out,                       // AHB response, always OKAY
  input  wire logic        halt_in,                         // CPU halt instruction, one cycle
  input  wire logic        wake_in,                         // Accepted wake interrupt, one cycle
  input  wire logic        timekeeper_select_in,            // Timekeeping time base selected
  output logic      [3:0]  mode_out,                        // Encoded operating mode
  output logic             cpu_on_subclock_out,             // CPU runs on subclock
  output logic             cpu_clk_hold_out,                // Chip clock withheld
  output logic             exc_start_out,                   // Start interrupt handling, pulse
  output logic      [7:0]  med_div_ratio_out,               // Oscillator divide, medium speed
  output logic      [3:0]  sub_div_ratio_out,               // Watch clock divide, subactive
  output logic      [4:0]  noise_div_ratio_out,             // Watch clock sample divide
  output logic             port_hiz_out,                    // Port outputs high impedance
  output logic             ext_irq_ignore_out,              // External interrupt lines ignored
  output logic             watch_timer_run_out              // Watch timer allowed to run
);

  // ********************************************
  // Helper functions
  // ********************************************
  // Settling length minus one; codes with the top bit set all give the longest wait
  function automatic logic [PMC_CNT_W-1:0] wait_load(input logic [2:0] code);
    logic [2:0] sh;
    sh = code[2] ? 3'd4 : code;
    return PMC_CNT_W'((WAIT_BASE_STATES << sh) - 1);        // see [RULE4]
  endfunction : wait_load

  // Mode after a halt instruction, from the register values of that cycle
  function automatic pmc_mode_t halt_target(input pmc_mode_t cur, input logic [7:0] r1,
                                            input logic [7:0] r2, input logic tk);
    logic ds;
    logic lc;
    logic ms;
    logic dt;
    pmc_mode_t low;
    ds = r1[PMC_DEEP_STOP_BIT];
    lc = r1[PMC_LOW_CLK_BIT];
    ms = r2[PMC_MED_SPEED_BIT];
    dt = r2[PMC_DIRECT_BIT];
    low = cur;
    if (cur == PMC_SUBACT) begin
      low = ds ? PMC_WATCH : PMC_SUBSLEEP;                  // see [RULE2] see [RULE3] see [RULE12]
      if (dt && ds && tk && !lc) begin
        low = ms ? PMC_ACT_MS : PMC_ACT_HS;                 // see [RULE15]
      end
    end else if (cur == PMC_ACT_HS || cur == PMC_ACT_MS) begin
      if (ds) begin
        low = tk ? PMC_WATCH : PMC_STANDBY;                 // see [RULE3] see [RULE22]
      end else begin
        low = ms ? PMC_SLEEP_MS : PMC_SLEEP_HS;             // see [RULE2] see [RULE16]
      end
      if (dt && ds && tk && lc) begin
        low = PMC_SUBACT;                                   // see [RULE13] see [RULE14]
      end else if (dt && !ds && !lc && cur == PMC_ACT_HS && ms) begin
        low = PMC_ACT_MS;                                   // see [RULE13]
      end else if (dt && !ds && !lc && cur == PMC_ACT_MS && !ms) begin
        low = PMC_ACT_HS;                                   // see [RULE14]
      end
    end
    return low;
  endfunction : halt_target

  // ********************************************
  // State
  // ********************************************
  logic [7:0]           ctrl1_reg;
  logic [7:0]           ctrl1_next;
  logic [7:0]           ctrl2_reg;
  logic [7:0]           ctrl2_next;
  logic                 wr_pend_reg;
  logic                 wr_sel1_reg;
  logic                 wr_sel2_reg;
  logic [31:0]          hrdata_reg;
  pmc_mode_t            mode_reg;
  pmc_mode_t            mode_next;
  logic [PMC_CNT_W-1:0] cnt_reg;
  logic [PMC_CNT_W-1:0] cnt_next;
  logic                 settle_ms_reg;
  logic                 settle_ms_next;
  logic                 exc_next;

  // ********************************************
  // Bus decode
  // ********************************************
  // Zero wait states; the slave takes every address phase offered to it
  wire        addr_phase = hsel_in & htrans_in[1] & hready_in;
  wire        hit1       = haddr_in == PMC_CTRL1_ADDR;
  wire        hit2       = haddr_in == PMC_CTRL2_ADDR;
  wire        rd_take    = addr_phase & ~hwrite_in;
  wire        wr_take    = addr_phase & hwrite_in;
  wire [7:0]  wbyte      = hwdata_in[7:0];
  wire        in_subact  = mode_reg == PMC_SUBACT;

  // Fixed bits forced on every write; subclock divider held while subactive
  wire [7:0]  w1_val     = wbyte | PMC_CTRL1_FIXED;         // see [RULE1]
  wire [7:0]  w2_raw     = wbyte | PMC_CTRL2_FIXED;         // see [RULE9]
  wire [7:0]  w2_val     = in_subact ? {w2_raw[7:2], ctrl2_reg[1:0]} : w2_raw;  // see [RULE18]
  assign ctrl1_next = (wr_pend_reg && wr_sel1_reg) ? w1_val : ctrl1_reg;
  assign ctrl2_next = (wr_pend_reg && wr_sel2_reg) ? w2_val : ctrl2_reg;

  // Read data uses next values so a write just before a read is seen
  wire [31:0] rd_val     = hit1 ? {24'h000000, ctrl1_next} :
                           hit2 ? {24'h000000, ctrl2_next} : 32'h00000000;

  // ********************************************
  // Bus registers
  // ********************************************
  // Address phase captured for the data phase that follows
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_pend_reg <= 1'b0;
      wr_sel1_reg <= 1'b0;
      wr_sel2_reg <= 1'b0;
      hrdata_reg  <= 32'h00000000;
    end else begin
      wr_pend_reg <= wr_take;
      wr_sel1_reg <= wr_take & hit1;
      wr_sel2_reg <= wr_take & hit2;
      if (rd_take) begin
        hrdata_reg <= rd_val;
      end
    end
  end

  // Control registers
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl1_reg <= PMC_CTRL1_RST;                           // see [RULE1]
      ctrl2_reg <= PMC_CTRL2_RST;                           // see [RULE9]
    end else begin
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
    end
  end

  // ********************************************
  // Mode sequencer
  // ********************************************
  wire ms_now = ctrl2_reg[PMC_MED_SPEED_BIT];
  wire lc_now = ctrl1_reg[PMC_LOW_CLK_BIT];

  // Halt is only honoured while the CPU executes; wakes only in halted modes
  always_comb begin
    mode_next      = mode_reg;
    cnt_next       = cnt_reg;
    settle_ms_next = settle_ms_reg;
    exc_next       = 1'b0;
    unique case (mode_reg)
      PMC_ACT_HS, PMC_ACT_MS, PMC_SUBACT: begin
        if (halt_in) begin
          mode_next = halt_target(mode_reg, ctrl1_reg, ctrl2_reg, timekeeper_select_in);  // see [RULE24]
        end
      end
      PMC_SLEEP_HS: begin
        if (wake_in) begin
          mode_next = PMC_ACT_HS;
          exc_next  = 1'b1;
        end
      end
      PMC_SLEEP_MS: begin
        if (wake_in) begin
          mode_next = PMC_ACT_MS;
          exc_next  = 1'b1;
        end
      end
      PMC_SUBSLEEP: begin
        if (wake_in) begin
          mode_next = PMC_SUBACT;
          exc_next  = 1'b1;
        end
      end
      PMC_STANDBY, PMC_WATCH: begin
        if (wake_in && mode_reg == PMC_WATCH && lc_now) begin
          mode_next = PMC_SUBACT;                           // see [RULE6]
          exc_next  = 1'b1;
        end else if (wake_in) begin
          mode_next      = PMC_SETTLE;                      // see [RULE6]
          cnt_next       = wait_load(ctrl1_reg[PMC_WAIT_SEL_LSB +: 3]);  // see [RULE4]
          settle_ms_next = ms_now;                          // see [RULE16]
        end
      end
      PMC_SETTLE: begin
        if (cnt_reg == '0) begin
          mode_next = settle_ms_reg ? PMC_ACT_MS : PMC_ACT_HS;  // see [RULE23]
          exc_next  = 1'b1;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        mode_next = PMC_ACT_HS;                             // Illegal code recovers to reset mode
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_reg      <= PMC_ACT_HS;
      cnt_reg       <= '0;
      settle_ms_reg <= 1'b0;
    end else begin
      mode_reg      <= mode_next;
      cnt_reg       <= cnt_next;
      settle_ms_reg <= settle_ms_next;
    end
  end

  // ********************************************
  // Output decode
  // ********************************************
  wire       nx_sub_fam = mode_next == PMC_WATCH || mode_next == PMC_SUBACT || mode_next == PMC_SUBSLEEP;
  wire       nx_hold    = mode_next == PMC_STANDBY || mode_next == PMC_WATCH || mode_next == PMC_SETTLE;
  wire       nx_hiz     = mode_next == PMC_STANDBY;             // see [RULE19]
  wire       nx_irq_ign = mode_next == PMC_STANDBY || mode_next == PMC_WATCH;  // see [RULE20]
  wire       nx_sub_clk = mode_next == PMC_SUBACT || mode_next == PMC_SUBSLEEP;  // see [RULE6]
  wire       nx_wt_run  = nx_sub_fam ? timekeeper_select_in : 1'b1;  // see [RULE21]
  wire [7:0] nx_med_div = PMC_MED_DIV_MIN << ctrl1_next[PMC_MED_DIV_LSB +: 2];  // see [RULE7]
  wire [3:0] nx_sub_div = ctrl2_next[PMC_SUB_DIV_LSB + 1] ? (PMC_SUB_DIV_MAX >> 2) :
                          (PMC_SUB_DIV_MAX >> ctrl2_next[PMC_SUB_DIV_LSB]);  // see [RULE17]
  wire [4:0] nx_noise   = ctrl2_next[PMC_NOISE_BIT] ? PMC_NOISE_DIV_FAST : PMC_NOISE_DIV_SLOW;  // see [RULE10]

  // Each decoded output comes from a flop loaded with the value for the next cycle
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cpu_on_subclock_out <= 1'b0;
      cpu_clk_hold_out    <= 1'b0;
      exc_start_out       <= 1'b0;
      med_div_ratio_out   <= 8'h80;
      sub_div_ratio_out   <= PMC_SUB_DIV_MAX;
      noise_div_ratio_out <= PMC_NOISE_DIV_SLOW;
      port_hiz_out        <= 1'b0;
      ext_irq_ignore_out  <= 1'b0;
      watch_timer_run_out <= 1'b1;
    end else begin
      cpu_on_subclock_out <= nx_sub_clk;
      cpu_clk_hold_out    <= nx_hold;                       // see [RULE23]
      exc_start_out       <= exc_next;
      med_div_ratio_out   <= nx_med_div;
      sub_div_ratio_out   <= nx_sub_div;
      noise_div_ratio_out <= nx_noise;
      port_hiz_out        <= nx_hiz;
      ext_irq_ignore_out  <= nx_irq_ign;
      watch_timer_run_out <= nx_wt_run;
    end
  end

  assign mode_out      = mode_reg;                          // see [RULE24]
  assign hrdata_out    = hrdata_reg;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

endmodule : pmc_power_mode_ctrl

//--- verification/pmc_cpu_model.sv
`timescale 1ns/1ns
// ************************************************
// CPU core stand-in: halt and wake pulses
// ************************************************
module pmc_cpu_model (
  input  wire logic clk_sys_in,    // System clock
  input  wire logic nrst_in,       // Reset, active low
  input  wire logic halt_req_in,   // Bench asks for a halt
  input  wire logic wake_req_in,   // Bench asks for a wake
  output logic      halt_out,      // Halt instruction pulse
  output logic      wake_out       // Accepted interrupt pulse
);
  // Registered like a real core, so pulses leave one edge after the request
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      halt_out <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      halt_out <= halt_req_in;
      wake_out <= wake_req_in;
    end
  end
endmodule : pmc_cpu_model

//--- verification/pmc_power_mode_ctrl_properties.sv
`timescale 1ns/1ns
// ************************************************
// Mode and clock control checker
// ************************************************
module pmc_power_mode_ctrl_properties
  import pmc_pkg::*;
#(
  parameter int WAIT_BASE_STATES = PMC_WAIT_STATES_MIN    // Shortest settling wait
) (
  input wire logic       clk_sys_in,            // System clock
  input wire logic       nrst_in,               // Reset, active low
  input wire logic       halt_in,               // Halt pulse
  input wire logic       wake_in,               // Wake pulse
  input wire logic [3:0] mode_out,              // Encoded mode
  input wire logic       cpu_on_subclock_out,   // Subclock select
  input wire logic       cpu_clk_hold_out,      // Clock withheld
  input wire logic       exc_start_out,         // Exception start
  input wire logic [7:0] med_div_ratio_out,     // Medium divide
  input wire logic [3:0] sub_div_ratio_out,     // Subclock divide
  input wire logic [4:0] noise_div_ratio_out,   // Noise divide
  input wire logic       port_hiz_out,          // Ports floated
  input wire logic       ext_irq_ignore_out,    // Lines ignored
  input wire logic       watch_timer_run_out    // Timer enable
);
  logic [17:0] settle_cnt_reg;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // Counts settling cycles, since the design keeps its own count hidden
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      settle_cnt_reg <= 18'h00000;
    end else begin
      settle_cnt_reg <= (mode_out == PMC_SETTLE) ? settle_cnt_reg + 18'h00001 : 18'h00000;
    end
  end
  sequence s_standby_wake; (mode_out == PMC_STANDBY) && wake_in; endsequence
  sequence s_settle_exit; (mode_out == PMC_SETTLE) ##1 (mode_out != PMC_SETTLE); endsequence
  a_port_float_standby: assert property (port_hiz_out == (mode_out == PMC_STANDBY))
    else $error("port float flag disagrees with mode");
  a_irq_ignore_held: assert property (
    ext_irq_ignore_out == (mode_out inside {PMC_STANDBY, PMC_WATCH}))
    else $error("interrupt ignore flag disagrees with mode");
  a_subclock_mode_match: assert property (
    cpu_on_subclock_out == (mode_out inside {PMC_SUBACT, PMC_SUBSLEEP}))
    else $error("subclock select disagrees with mode");
  a_clock_hold_mode: assert property (
    cpu_clk_hold_out == (mode_out inside {PMC_STANDBY, PMC_WATCH, PMC_SETTLE}))
    else $error("clock hold disagrees with mode");
  a_timer_runs_free: assert property (
    !(mode_out inside {PMC_WATCH, PMC_SUBACT, PMC_SUBSLEEP}) |-> watch_timer_run_out)
    else $error("watch timer stopped outside sub modes");
  a_run_mode_holds: assert property (
    (mode_out inside {PMC_ACT_HS, PMC_ACT_MS, PMC_SUBACT}) && !halt_in |=> $stable(mode_out))
    else $error("running mode changed without halt");
  a_standby_wake_settles: assert property (s_standby_wake |=> mode_out == PMC_SETTLE)
    else $error("standby wake did not start settling");
  a_settle_exit_exc: assert property (
    s_settle_exit |-> exc_start_out && (mode_out inside {PMC_ACT_HS, PMC_ACT_MS}))
    else $error("settling ended without exception start into active mode");
  a_exc_single_cycle: assert property (exc_start_out |=> !exc_start_out)
    else $error("exception start longer than one cycle");
  a_settle_length: assert property ((settle_cnt_reg != 0) && (mode_out != PMC_SETTLE) |->
    (settle_cnt_reg >= WAIT_BASE_STATES) && (settle_cnt_reg <= 16 * WAIT_BASE_STATES))
    else $error("settling length out of range");
  a_divider_codes: assert property (
    (med_div_ratio_out inside {8'h10, 8'h20, 8'h40, 8'h80}) &&
    (sub_div_ratio_out inside {4'h8, 4'h4, 4'h2}) && (noise_div_ratio_out inside {5'h10, 5'h04}))
    else $error("divider value off");
  a_sub_div_frozen: assert property (
    (mode_out == PMC_SUBACT) ##1 (mode_out == PMC_SUBACT) |-> $stable(sub_div_ratio_out))
    else $error("subclock divide changed during subactive");
endmodule : pmc_power_mode_ctrl_properties

bind pmc_power_mode_ctrl pmc_power_mode_ctrl_properties #(.WAIT_BASE_STATES(WAIT_BASE_STATES)) u_props (
  .clk_sys_in, .nrst_in, .halt_in, .wake_in, .mode_out, .cpu_on_subclock_out, .cpu_clk_hold_out, .exc_start_out,
  .med_div_ratio_out, .sub_div_ratio_out, .noise_div_ratio_out, .port_hiz_out, .ext_irq_ignore_out,
  .watch_timer_run_out);

//--- verification/test_power_mode_control_registers.sv
`timescale 1ns/1ns
module test_power_mode_control_registers
  import pmc_pkg::*;
;
  logic        clk_sys_in = 1'b0, nrst_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0, timekeeper_select_in = 1'b0;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, v;
  logic [1:0]  htrans_in = 2'h0;
  logic [2:0]  hsize_in = 3'h0;
  logic [7:0]  med_div_ratio_out;
  logic [4:0]  noise_div_ratio_out;
  logic [3:0]  mode_out, sub_div_ratio_out;
  logic        hready_in, hreadyout_out, hresp_out, halt_in, wake_in, halt_req = 1'b0, wake_req = 1'b0;
  logic        cpu_on_subclock_out, cpu_clk_hold_out, exc_start_out, port_hiz_out, ext_irq_ignore_out;
  logic        watch_timer_run_out;
  int          n_fail = 0, check_count = 0, cnt, c;
  assign hready_in = hreadyout_out;   // Single slave drives the bus ready
  always #50 clk_sys_in = ~clk_sys_in;
  pmc_power_mode_ctrl #(.WAIT_BASE_STATES(4)) dut (.clk_sys_in, .nrst_in, .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hsize_in, .hready_in, .hwdata_in, .hrdata_out, .hreadyout_out, .hresp_out, .halt_in, .wake_in,
    .timekeeper_select_in, .mode_out, .cpu_on_subclock_out, .cpu_clk_hold_out, .exc_start_out, .med_div_ratio_out,
    .sub_div_ratio_out, .noise_div_ratio_out, .port_hiz_out, .ext_irq_ignore_out, .watch_timer_run_out);
  pmc_cpu_model cpu (.clk_sys_in, .nrst_in, .halt_req_in(halt_req), .wake_req_in(wake_req), .halt_out(halt_in),
    .wake_out(wake_in));
  // ************************************************
  // Bench tasks
  // ************************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Waits for ready at a rising edge; a stuck bus ends the run
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (hready_in !== 1'b1 && k < 20);
    if (hready_in !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : wait_rdy
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= a;
    hwrite_in <= wr;
    hsize_in <= 3'h2;
    wait_rdy();
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= {24'h0, d};
    wait_rdy();
    v = hrdata_out;
  endtask : xfer
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 8'h00);
    chk("register read", exp, v);
    chk("response", 32'h0, {31'h0, hresp_out});
  endtask : rchk
  // Halt or wake through the core model; mode is looked at once it has landed
  task automatic act(input logic h, input logic [3:0] exp_mode);
    @(posedge clk_sys_in);
    halt_req <= h;
    wake_req <= !h;
    @(posedge clk_sys_in);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk("mode", {28'h0, exp_mode}, {28'h0, mode_out});
  endtask : act
  task automatic tk(input logic t);
    @(posedge clk_sys_in);
    timekeeper_select_in <= t;
  endtask : tk
  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    repeat (16) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rchk(PMC_CTRL1_ADDR, 32'h07);
    rchk(PMC_CTRL2_ADDR, 32'he0);
    rchk(PMC_CTRL2_ADDR + 32'h8, 32'h0);
    chk("med div", 32'h80, {24'h0, med_div_ratio_out});
    chk("sub div", 32'h8, {28'h0, sub_div_ratio_out});
    chk("noise div", 32'h10, {27'h0, noise_div_ratio_out});
    xfer(1'b1, PMC_CTRL1_ADDR, 8'h00);
    rchk(PMC_CTRL1_ADDR, 32'h04);
    // Divider codes are written in high-speed active mode only
    for (c = 0; c < 4; c++) begin
      xfer(1'b1, PMC_CTRL1_ADDR, 8'(c));
      xfer(1'b1, PMC_CTRL2_ADDR, {3'h0, c[0], 2'h0, c[1:0]});
      @(negedge clk_sys_in);                                           // Outputs land on the write's last edge
      chk("med div", 32'h10 << c, {24'h0, med_div_ratio_out});
      chk("sub div", c[1] ? 32'h2 : (c[0] ? 32'h4 : 32'h8), {28'h0, sub_div_ratio_out});
      chk("noise div", c[0] ? 32'h4 : 32'h10, {27'h0, noise_div_ratio_out});
    end
    xfer(1'b1, PMC_CTRL2_ADDR, 8'h00);
    rchk(PMC_CTRL2_ADDR, 32'he0);
    xfer(1'b1, PMC_CTRL1_ADDR, 8'h00);
    act(1'b1, PMC_SLEEP_HS);
    act(1'b1, PMC_SLEEP_HS);
    act(1'b0, PMC_ACT_HS);
    chk("exc start", 32'h1, {31'h0, exc_start_out});
    xfer(1'b1, PMC_CTRL2_ADDR, 8'h04);
    act(1'b1, PMC_SLEEP_MS);
    act(1'b0, PMC_ACT_MS);
    act(1'b0, PMC_ACT_MS);
    xfer(1'b1, PMC_CTRL2_ADDR, 8'h00);
    // Wait codes 0 to 4 and 7, the top bit alone picking the longest wait; the last pass leaves watch
    for (c = 0; c < 6; c++) begin
      tk(c == 5);
      xfer(1'b1, PMC_CTRL1_ADDR, {1'b1, (c == 5) ? 3'h7 : 3'(c), 4'h3});
      act(1'b1, (c == 5) ? PMC_WATCH : PMC_STANDBY);
      chk("port float", {31'h0, c != 5}, {31'h0, port_hiz_out});
      chk("clock hold", 32'h1, {31'h0, cpu_clk_hold_out});
      act(1'b0, PMC_SETTLE);
      cnt = 0;
      while (mode_out === PMC_SETTLE && cnt < 200) begin
        cnt++;
        @(negedge clk_sys_in);
      end
      if (cnt >= 200) begin
        n_fail++;
        tally_and_finish();
      end
      chk("settle cycles", 32'(4 << ((c > 4) ? 4 : c)), 32'(cnt));
      chk("wake mode", {28'h0, PMC_ACT_HS}, {28'h0, mode_out});
      chk("exc start", 32'h1, {31'h0, exc_start_out});
    end
    tk(1'b1);
    xfer(1'b1, PMC_CTRL1_ADDR, 8'h88);
    act(1'b1, PMC_WATCH);
    chk("irq ignore", 32'h1, {31'h0, ext_irq_ignore_out});
    act(1'b0, PMC_SUBACT);
    chk("on subclock", 32'h1, {31'h0, cpu_on_subclock_out});
    xfer(1'b1, PMC_CTRL2_ADDR, 8'h03);
    @(negedge clk_sys_in);
    chk("sub div", 32'h8, {28'h0, sub_div_ratio_out});
    act(1'b1, PMC_WATCH);
    act(1'b0, PMC_SUBACT);
    xfer(1'b1, PMC_CTRL1_ADDR, 8'h08);
    act(1'b1, PMC_SUBSLEEP);
    tk(1'b0);
    repeat (2) @(negedge clk_sys_in);
    chk("watch timer", 32'h0, {31'h0, watch_timer_run_out});
    tk(1'b1);
    act(1'b0, PMC_SUBACT);
    xfer(1'b1, PMC_CTRL2_ADDR, 8'h0c);
    xfer(1'b1, PMC_CTRL1_ADDR, 8'h80);
    act(1'b1, PMC_ACT_MS);
    xfer(1'b1, PMC_CTRL2_ADDR, 8'h08);
    xfer(1'b1, PMC_CTRL1_ADDR, 8'h00);
    act(1'b1, PMC_ACT_HS);
    xfer(1'b1, PMC_CTRL2_ADDR, 8'h0c);
    act(1'b1, PMC_ACT_MS);
    xfer(1'b1, PMC_CTRL1_ADDR, 8'h88);
    act(1'b1, PMC_SUBACT);
    tally_and_finish();
  end
endmodule : test_power_mode_control_registers
